// ### hdl/apbd_decoder.sv
// Pass-through command block decoder: APB registers in, taskfile requests out.
// Assumes the taskfile engine runs on CORE_CLK and acks each held request once.
//
// The APB interface to the registers and the register addresses were left to the implementer.
module apbd_decoder #(
	parameter logic [15:0] EXT_SIG = 16'hA55A
) (
	// Clock and reset.
	input wire logic CORE_CLK,
	input wire logic ARST_N,
	// APB slave.
	input wire logic PSEL,
	input wire logic PENABLE,
	input wire logic PWRITE,
	input wire logic [7:0] PADDR,
	input wire logic [31:0] PWDATA,
	output logic [31:0] PRDATA,
	output logic PREADY,
	output logic PSLVERR,
	// Taskfile engine.
	output apbd_pkg::apbd_tf_cmd_type TF_CMD,
	input wire logic TF_ACK,
	input wire logic [7:0] TF_RDATA
);
	import apbd_pkg::*;

	apbd_state_type s;
	apbd_state_type n;
	logic ext_hit;
	logic chk_fail;
	logic [8:0] chk_sectors;
	logic apb_wr;
	logic start;
	logic mapped;
	logic [7:0] sel;
	logic [7:0] act;
	logic [63:0] sel_mask;

	// Extended signature value is arbitrary and only used to tell the block types apart.
	apbd_check #(
		.EXT_SIG(EXT_SIG)
	) u_check (
		.blk(s.blk),
		.ext_hit(ext_hit),
		.fail(chk_fail),
		.sectors(chk_sectors)
	);

	assign sel = s.blk[8*BYTE_SELECT +: 8];
	assign act = s.blk[8*BYTE_ACTION +: 8];
	assign apb_wr = PSEL && PENABLE && PWRITE;
	assign start = apb_wr && (PADDR == REG_CTRL) && PWDATA[CTRL_START] && !s.busy;

	genvar g;
	generate
		for (g = 0; g < 8; g = g + 1) begin : g_mask
			assign sel_mask[8*g +: 8] = {8{sel[g]}};
		end
	endgenerate

	// Accesses ascend from select bit 0, so device select already precedes the command.
	// The late bit only swaps the last two positions to put device select behind the command.
	function automatic logic [2:0] order(input logic [2:0] pos, input logic late);
		logic [2:0] idx;
		idx = pos;
		if (late) begin
			if (pos == IDX_DEVICE)
				idx = IDX_COMMAND;
			else if (pos == IDX_COMMAND)
				idx = IDX_DEVICE;
		end
		return idx;
	endfunction

	function automatic logic [7:0] wbyte(input logic [127:0] blk, input logic [2:0] idx);
		logic [3:0] bi;
		bi = BYTE_WDATA + {1'b0, idx};
		return blk[{bi, 3'b000} +: 8];
	endfunction

	always_comb begin
		logic [2:0] idx;
		idx = order(s.step[2:0], act[ACT_LATE]);
		n = s;
		// The block cannot change under a running command.
		if (apb_wr && !s.busy) begin
			unique case (PADDR)
				REG_CMD0: n.blk[31:0] = PWDATA;
				REG_CMD1: n.blk[63:32] = PWDATA;
				REG_CMD2: n.blk[95:64] = PWDATA;
				REG_CMD3: n.blk[127:96] = PWDATA;
				default: ;
			endcase
		end
		unique case (s.phase)
			PH_IDLE: begin
				if (start) begin
					n.rb = 64'h0;
					n.done = 1'b0;
					n.fail = 1'b0;
					n.ext = ext_hit;
					n.step = 4'h0;
					n.sectors = chk_sectors;
					if (chk_fail) begin
						n.done = 1'b1;
						n.fail = 1'b1;
					end else begin
						n.busy = 1'b1;
						n.phase = act[ACT_SKIP] ? PH_ACCESS : PH_POLL;
					end
				end
			end
			PH_POLL: begin
				if (!s.tf.req) begin
					n.tf.req = 1'b1;
					n.tf.write = 1'b0;
					n.tf.index = IDX_ALT;
				end else if (TF_ACK) begin
					n.tf.req = 1'b0;
					if (!TF_RDATA[BUSY_BIT])
						n.phase = PH_ACCESS;
				end
			end
			PH_ACCESS: begin
				if (s.step[3]) begin
					n.phase = PH_IDLE;
					n.busy = 1'b0;
					n.done = 1'b1;
				end else if (!s.tf.req) begin
					if (sel[idx]) begin
						n.tf.req = 1'b1;
						n.tf.write = !act[ACT_READBACK];
						n.tf.index = idx;
						n.tf.wdata = wbyte(s.blk, idx);
					end else begin
						n.step = s.step + 4'h1;
					end
				end else if (TF_ACK) begin
					n.tf.req = 1'b0;
					n.step = s.step + 4'h1;
					if (!s.tf.write)
						n.rb[{s.tf.index, 3'b000} +: 8] = TF_RDATA;
				end
			end
			default: n.phase = PH_IDLE;
		endcase
	end

	always_ff @(posedge CORE_CLK or negedge ARST_N) begin
		if (!ARST_N)
			s <= '0;
		else
			s <= n;
	end

	assign TF_CMD = s.tf;

	// Reads come straight from the registers; no wait states are ever inserted.
	always_comb begin
		mapped = 1'b1;
		PRDATA = RESET_WORD;
		unique case (PADDR)
			REG_CMD0: PRDATA = s.blk[31:0];
			REG_CMD1: PRDATA = s.blk[63:32];
			REG_CMD2: PRDATA = s.blk[95:64];
			REG_CMD3: PRDATA = s.blk[127:96];
			REG_CTRL: PRDATA = RESET_WORD;
			REG_STATUS: begin
				PRDATA[ST_BUSY] = s.busy;
				PRDATA[ST_DONE] = s.done;
				PRDATA[ST_FAIL] = s.fail;
				PRDATA[ST_EXT] = s.ext;
				PRDATA[ST_SECTORS +: 9] = s.sectors;
			end
			REG_RB0: PRDATA = s.rb[31:0];
			REG_RB1: PRDATA = s.rb[63:32];
			default: mapped = 1'b0;
		endcase
	end

	assign PREADY = 1'b1;
	assign PSLVERR = PSEL && PENABLE && !mapped;

	property p_bad_count;
		@(posedge CORE_CLK) disable iff (!ARST_N)
		(start && !$onehot0(s.blk[8*BYTE_COUNT +: 8])) |=> (s.done && s.fail && !s.busy);
	endproperty
	a_bad_count: assert property (p_bad_count) else $error("illegal block count accepted");

	property p_zero_count;
		@(posedge CORE_CLK) disable iff (!ARST_N)
		(start && s.blk[8*BYTE_COUNT +: 8] == 8'h00) |=> (s.sectors == 9'h100);
	endproperty
	a_zero_count: assert property (p_zero_count) else $error("zero count not 256 sectors");

	property p_ext_not_run;
		@(posedge CORE_CLK) disable iff (!ARST_N)
		(start && {s.blk[7:0], s.blk[15:8]} == EXT_SIG) |=> (s.ext && s.fail) ##1 !s.tf.req;
	endproperty
	a_ext_not_run: assert property (p_ext_not_run) else $error("extended block was executed");

	property p_reserved;
		@(posedge CORE_CLK) disable iff (!ARST_N)
		(start && s.blk[127:104] != 24'h00_0000) |=> (s.fail && !s.busy);
	endproperty
	a_reserved: assert property (p_reserved) else $error("nonzero reserved bytes accepted");

	property p_unselected_zero;
		@(posedge CORE_CLK) disable iff (!ARST_N)
		s.busy |-> ((s.rb & ~sel_mask) == 64'h0);
	endproperty
	a_unselected_zero: assert property (p_unselected_zero) else $error("unselected readback byte nonzero");

	property p_select_gate;
		@(posedge CORE_CLK) disable iff (!ARST_N)
		(s.tf.req && s.phase == PH_ACCESS) |-> sel[s.tf.index];
	endproperty
	a_select_gate: assert property (p_select_gate) else $error("access to unselected register");

	property p_write_map;
		@(posedge CORE_CLK) disable iff (!ARST_N)
		(s.tf.req && s.tf.write) |-> (s.tf.wdata == wbyte(s.blk, s.tf.index));
	endproperty
	a_write_map: assert property (p_write_map) else $error("write byte taken from wrong position");

	property p_readback_no_write;
		@(posedge CORE_CLK) disable iff (!ARST_N)
		(s.tf.req && act[ACT_READBACK]) |-> !s.tf.write;
	endproperty
	a_readback_no_write: assert property (p_readback_no_write) else $error("write during readback only");

	property p_poll_first;
		@(posedge CORE_CLK) disable iff (!ARST_N)
		(start && !chk_fail && !act[ACT_SKIP]) |-> ##2 (s.tf.req && !s.tf.write && s.tf.index == IDX_ALT);
	endproperty
	a_poll_first: assert property (p_poll_first) else $error("alternate status not polled first");

	c_readback: cover property (@(posedge CORE_CLK) disable iff (!ARST_N) $rose(s.done) && act[ACT_READBACK] && !s.fail);
	c_write: cover property (@(posedge CORE_CLK) disable iff (!ARST_N) $rose(s.done) && !act[ACT_READBACK] && !s.fail);
	c_fail: cover property (@(posedge CORE_CLK) disable iff (!ARST_N) $rose(s.fail));
	c_poll_busy: cover property (@(posedge CORE_CLK) disable iff (!ARST_N)
		s.phase == PH_POLL && TF_ACK && TF_RDATA[BUSY_BIT]);
endmodule

// ### common/apbd_pkg.sv
// Constants and types for the ATA pass-through command block decoder.
// Assumes a 32-bit APB master and a taskfile engine on the same clock that answers each request with an ack.
package apbd_pkg;
	// Register byte addresses.
	localparam logic [7:0] REG_CMD0 = 8'h00;
	localparam logic [7:0] REG_CMD1 = 8'h04;
	localparam logic [7:0] REG_CMD2 = 8'h08;
	localparam logic [7:0] REG_CMD3 = 8'h0C;
	localparam logic [7:0] REG_CTRL = 8'h10;
	localparam logic [7:0] REG_STATUS = 8'h14;
	localparam logic [7:0] REG_RB0 = 8'h18;
	localparam logic [7:0] REG_RB1 = 8'h1C;
	// Control and status field positions.
	localparam int CTRL_START = 0;
	localparam int ST_BUSY = 0;
	localparam int ST_DONE = 1;
	localparam int ST_FAIL = 2;
	localparam int ST_EXT = 3;
	localparam int ST_SECTORS = 16;
	// Command block byte positions.
	localparam int BYTE_SIG_HI = 0;
	localparam int BYTE_SIG_LO = 1;
	localparam int BYTE_SUB = 1;
	localparam int BYTE_ACTION = 2;
	localparam int BYTE_SELECT = 3;
	localparam int BYTE_COUNT = 4;
	localparam logic [3:0] BYTE_WDATA = 4'h5;
	localparam int BYTE_RSV = 13;
	localparam int RSV_BYTES = 3;
	// Action bits.
	localparam int ACT_READBACK = 0;
	localparam int ACT_LATE = 1;
	localparam int ACT_SKIP = 2;
	// Codes and values.
	localparam logic [7:0] SUB_STD = 8'h24;
	localparam logic [8:0] SECTORS_ZERO = 9'h100;
	localparam logic [2:0] IDX_ALT = 3'h0;
	localparam logic [2:0] IDX_DEVICE = 3'h6;
	localparam logic [2:0] IDX_COMMAND = 3'h7;
	localparam int BUSY_BIT = 7;
	localparam logic [31:0] RESET_WORD = 32'h0000_0000;

	typedef enum logic [1:0] {PH_IDLE, PH_POLL, PH_ACCESS} apbd_phase_type;

	// One taskfile request: held until the engine acks it.
	typedef struct packed {
		logic req;
		logic write;
		logic [2:0] index;
		logic [7:0] wdata;
	} apbd_tf_cmd_type;

	typedef struct packed {
		apbd_phase_type phase;
		logic [3:0] step;
		logic [127:0] blk;
		logic [63:0] rb;
		logic busy;
		logic done;
		logic fail;
		logic ext;
		logic [8:0] sectors;
		apbd_tf_cmd_type tf;
	} apbd_state_type;
endpackage

// ### hdl/apbd_check.sv
// Validity check of a command block held as 16 bytes, byte 0 in the low bits.
// Assumes the block is stable while its verdict is used.
module apbd_check #(
	parameter logic [15:0] EXT_SIG = 16'hA55A
) (
	// Command block.
	input wire logic [127:0] blk,
	// Verdict.
	output logic ext_hit,
	output logic fail,
	output logic [8:0] sectors
);
	import apbd_pkg::*;

	logic [7:0] cnt;
	logic legal;
	logic rsv_clear;

	assign cnt = blk[8*BYTE_COUNT +: 8];
	// Zero or a single set bit: 0, 1, 2, 4 ... 128.
	assign legal = (cnt == 8'h00) || $onehot(cnt);
	assign sectors = (cnt == 8'h00) ? SECTORS_ZERO : {1'b0, cnt};
	assign rsv_clear = (blk[8*BYTE_RSV +: 8*RSV_BYTES] == 24'h00_0000);
	// The extended block is recognised only by its signature and is not run here.
	assign ext_hit = ({blk[8*BYTE_SIG_HI +: 8], blk[8*BYTE_SIG_LO +: 8]} == EXT_SIG);
	assign fail = ext_hit || (blk[8*BYTE_SUB +: 8] != SUB_STD) || !rsv_clear || !legal;
endmodule

// ### verif/apbd_drive_model.sv
// Behavioural drive on the taskfile engine port; it logs every access that it acks.
// Assumes one held request at a time; the ack wait alternates between none and two cycles.
module apbd_drive_model
	import apbd_pkg::*;
(
	// Clock and reset.
	input wire logic core_clk,
	input wire logic arst_n,
	// Requests and answers.
	input wire apbd_pkg::apbd_tf_cmd_type tf_cmd,
	input wire logic [3:0] busy_polls,
	output logic tf_ack,
	output logic [7:0] tf_rdata
);
	timeunit 1ns;
	timeprecision 1ns;
	logic [7:0] regs [8];
	logic [3:0] polls;
	logic [1:0] hold;
	logic slow;
	logic [11:0] log_q [$];
	always @(posedge core_clk or negedge arst_n) begin
		if (!arst_n) begin
			tf_ack <= 1'b0;
			tf_rdata <= 8'h00;
			polls <= busy_polls;
			hold <= 2'h0;
			slow <= 1'b0;
			for (int i = 0; i < 8; i++) regs[i] <= 8'h10 + 8'(i);
		end else begin
			tf_ack <= 1'b0;
			// Read data outside an ack is scrambled so a stale value never looks valid.
			tf_rdata <= ~tf_rdata;
			if (tf_cmd.req && !tf_ack && hold != 2'h0)
				hold <= hold - 2'h1;
			else if (tf_cmd.req && !tf_ack) begin
				tf_ack <= 1'b1;
				slow <= ~slow;
				hold <= slow ? 2'h0 : 2'h2;
				log_q.push_back({tf_cmd.write, tf_cmd.index, tf_cmd.wdata});
				// The drive turns busy again after any access to an index other than IDX_ALT, so a write to index 0 does not.
				if (tf_cmd.index != IDX_ALT) polls <= busy_polls;
				if (tf_cmd.write) regs[tf_cmd.index] <= tf_cmd.wdata;
				else if (tf_cmd.index == IDX_ALT) begin
					tf_rdata <= polls != 4'h0 ? 8'hD0 : 8'h50;
					if (polls != 4'h0) polls <= polls - 4'h1;
				end else
					tf_rdata <= regs[tf_cmd.index];
			end
		end
	end
endmodule

// ### verif/ata_passthrough_block_decoder_tb.sv
// Bench for the pass-through decoder: APB register tasks, drive model on the taskfile port.
// Assumes the decoder answers APB with zero wait states and logs nothing for rejected blocks.
module ata_passthrough_block_decoder_tb;
	import apbd_pkg::*;
	timeunit 1ns;
	timeprecision 1ns;
	logic CORE_CLK = 1'b0;
	logic ARST_N = 1'b0;
	logic PSEL = 1'b0;
	logic PENABLE = 1'b0;
	logic PWRITE = 1'b0;
	logic [7:0] PADDR = 8'h00;
	logic [31:0] PWDATA = 32'h0;
	logic [31:0] PRDATA, q, st;
	logic PREADY, PSLVERR, err, TF_ACK;
	logic [7:0] TF_RDATA;
	apbd_tf_cmd_type TF_CMD;
	int miscompares = 0;
	int total_checks = 0;
	int cycles = 0;
	logic [11:0] exp_q [$];
	logic [7:0] cnts [6] = '{8'h00, 8'h02, 8'h40, 8'h03, 8'hFF, 8'h81};
	apbd_decoder DUT (.CORE_CLK(CORE_CLK), .ARST_N(ARST_N), .PSEL(PSEL), .PENABLE(PENABLE), .PWRITE(PWRITE),
		.PADDR(PADDR), .PWDATA(PWDATA), .PRDATA(PRDATA), .PREADY(PREADY), .PSLVERR(PSLVERR),
		.TF_CMD(TF_CMD), .TF_ACK(TF_ACK), .TF_RDATA(TF_RDATA));
	apbd_drive_model DRV (.core_clk(CORE_CLK), .arst_n(ARST_N), .tf_cmd(TF_CMD), .busy_polls(4'h2),
		.tf_ack(TF_ACK), .tf_rdata(TF_RDATA));
	initial forever #50 CORE_CLK = ~CORE_CLK;
	task automatic results();
		$display("checks %0d mismatches %0d", total_checks, miscompares);
		if (miscompares == 0 && total_checks > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask
	always @(posedge CORE_CLK) begin
		cycles <= cycles + 1;
		if (cycles == 30000) begin
			miscompares++;
			results();
		end
	end
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		total_checks++;
		if (seen !== exp) begin
			miscompares++;
			$display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
		@(posedge CORE_CLK);
		PSEL <= 1'b1;
		PWRITE <= wr;
		PADDR <= a;
		PWDATA <= d;
		@(posedge CORE_CLK);
		PENABLE <= 1'b1;
		do @(posedge CORE_CLK); while (PREADY !== 1'b1);
		q = PRDATA;
		err = PSLVERR;
		PSEL <= 1'b0;
		PENABLE <= 1'b0;
	endtask
	// Write data byte for register index i is A0 plus i, so a misrouted byte shows.
	task automatic run(input logic [7:0] b0, b1, act, sel, cnt, input logic [23:0] rsv);
		int n;
		DRV.log_q.delete();
		apb(1'b1, REG_CMD0, {sel, act, b1, b0});
		apb(1'b1, REG_CMD1, {24'hA2A1A0, cnt});
		apb(1'b1, REG_CMD2, 32'hA6A5A4A3);
		apb(1'b1, REG_CMD3, {rsv, 8'hA7});
		apb(1'b1, REG_CTRL, 32'h1);
		n = 0;
		do begin
			apb(1'b0, REG_STATUS, 32'h0);
			n++;
		end while (q[ST_DONE] !== 1'b1 && n < 200);
		st = q;
	endtask
	task automatic chk_seq(input logic [7:0] act, sel);
		logic [2:0] idx;
		if (!act[ACT_SKIP])
			for (int p = 0; p < 3; p++) exp_q.push_back(12'h000);
		for (int k = 0; k < 8; k++) begin
			idx = (act[ACT_LATE] && k >= 6) ? 3'(13 - k) : 3'(k);
			if (sel[idx])
				exp_q.push_back({!act[ACT_READBACK], idx, act[ACT_READBACK] ? 8'h00 : 8'hA0 + 8'(idx)});
		end
		chk(DRV.log_q.size(), exp_q.size());
		foreach (exp_q[i]) chk(exp_q[i][11] ? DRV.log_q[i] : DRV.log_q[i] & 12'hF00, exp_q[i]);
		exp_q.delete();
	endtask
	task automatic bad(input logic [7:0] b0, b1, input logic [23:0] rsv, input logic [31:0] exp);
		run(b0, b1, 8'h04, 8'hFF, 8'h01, rsv);
		chk(st & 32'hF, exp);
		chk(DRV.log_q.size(), 32'h0);
	endtask
	initial begin
		repeat (2) @(posedge CORE_CLK);
		ARST_N <= 1'b1;
		run(8'h00, SUB_STD, 8'h01, 8'hB5, 8'h10, 24'h0);
		chk(st & 32'h01FF_000F, 32'h0010_0002);
		chk_seq(8'h01, 8'hB5);
		apb(1'b0, REG_RB0, 32'h0);
		chk(q, 32'h0012_0050);
		apb(1'b0, REG_RB1, 32'h0);
		chk(q, 32'h1700_1514);
		chk({31'h0, err}, 32'h0);
		run(8'h00, SUB_STD, 8'h04, 8'hFF, 8'h08, 24'h0);
		chk_seq(8'h04, 8'hFF);
		run(8'h00, SUB_STD, 8'h06, 8'h41, 8'h80, 24'h0);
		chk_seq(8'h06, 8'h41);
		foreach (cnts[i]) begin
			run(8'h00, SUB_STD, 8'h04, 8'h00, cnts[i], 24'h0);
			if (i >= 3)
				chk(st & 32'hF, 32'h6);
			else
				chk(st & 32'h01FF_000F, {7'h0, cnts[i] == 8'h00 ? 9'h100 : {1'b0, cnts[i]}, 16'h0002});
		end
		bad(8'h00, SUB_STD, 24'h000001, 32'h6);
		bad(8'h00, SUB_STD, 24'h800000, 32'h6);
		bad(8'h00, 8'h25, 24'h0, 32'h6);
		bad(8'hA5, 8'h5A, 24'h0, 32'hE);
		apb(1'b0, 8'h20, 32'h0);
		chk(q, 32'h0);
		chk({31'h0, err}, 32'h1);
		results();
	end
endmodule
